/* rtl/cip_pkg.sv */
package cip_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CIP_OFF_CTRL = 8'h00;
  localparam logic [7:0] CIP_OFF_FMT = 8'h04;
  localparam logic [7:0] CIP_OFF_FDF = 8'h08;
  localparam logic [7:0] CIP_OFF_DELAY = 8'h0c;
  localparam logic [7:0] CIP_OFF_STAT = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CIP_CTRL_EN = 0;
  localparam int CIP_CTRL_RATE = 1;
  localparam int CIP_CTRL_SPH = 3;
  localparam int CIP_FMT_DFS = 0;
  localparam int CIP_FMT_FN = 8;
  localparam int CIP_FMT_QPC = 10;
  localparam int CIP_FMT_FNT = 16;
  localparam int CIP_FMT_SID = 24;
  localparam int CIP_STAT_DBC = 0;
  localparam int CIP_STAT_SENT = 8;
  localparam int CIP_STAT_FULL = 12;
  localparam int CIP_STAT_STATE = 13;

  // ---------------------------------------------------------------
  // reset values: transport stream profile
  // ---------------------------------------------------------------
  localparam logic CIP_RST_SPH = 1'b1;
  localparam logic [7:0] CIP_RST_DFS = 8'h06;
  localparam logic [1:0] CIP_RST_FN = 2'h3;
  localparam logic [2:0] CIP_RST_QPC = 3'h0;
  localparam logic [5:0] CIP_RST_FNT = 6'h20;
  localparam logic [1:0] CIP_RST_RATE = 2'h0;
  localparam logic [24:0] CIP_RST_DELAY = 25'h0;

  // ---------------------------------------------------------------
  // rate modes (max data blocks per cycle) and fixed header bits
  // ---------------------------------------------------------------
  localparam logic [1:0] CIP_RATE_ONE = 2'h0;
  localparam logic [1:0] CIP_RATE_TWO = 2'h1;
  localparam logic [1:0] CIP_RATE_FOUR = 2'h2;
  localparam logic [1:0] CIP_RATE_WHOLE = 2'h3;
  localparam logic [5:0] CIP_FNT_DVC = 6'h00;
  localparam logic [1:0] CIP_HDR0_TOP = 2'h0;
  localparam logic [1:0] CIP_HDR1_TOP = 2'h2;

  typedef enum logic [1:0] {
    CIP_IDLE = 2'b00,
    CIP_HDR0 = 2'b01,
    CIP_HDR1 = 2'b10,
    CIP_DATA = 2'b11
  } cip_state_type;

endpackage

/* rtl/cip_packer.sv */
`timescale 1ns/1ns
module cip_packer
#(
  parameter int MEM_DEPTH = 256
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // application stream in
  input wire logic [31:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // cycle timing
  input wire logic cycle_start_i,
  input wire logic [24:0] cyc_timer_i,
  input wire logic [15:0] syt_i,
  // link transmitter out
  output logic [31:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_sop_o,
  output logic tx_eop_o,
  output logic [11:0] tx_len_o,
  input wire logic tx_ready_i
);
  import cip_pkg::*;
  localparam int AW = $clog2(MEM_DEPTH);
  typedef struct packed {
    logic [MEM_DEPTH-1:0][31:0] mem;
    logic en;
    logic [1:0] rate;
    logic sph;
    logic [7:0] dfs;
    logic [1:0] fn;
    logic [2:0] qpc;
    logic [5:0] fnt;
    logic [5:0] sid;
    logic [23:0] fdf;
    logic [24:0] delay;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
    cip_state_type state;
    logic [11:0] wr_ptr;
    logic full;
    logic in_ready;
    logic [11:0] rd_ptr;
    logic [11:0] left;
    logic [3:0] sent;
    logic [3:0] nsend;
    logic [1:0] act_rate;
    logic [7:0] dbc;
    logic [7:0] hdr_dbc;
    logic [31:0] tx_data;
    logic tx_valid;
    logic tx_sop;
    logic tx_eop;
    logic [11:0] tx_len;
  } cip_regs_type;
  cip_regs_type r;
  cip_regs_type n;

  // ---------------------------------------------------------------
  // derived sizes
  // ---------------------------------------------------------------
  logic [8:0] blk_q;
  logic [3:0] nblk;
  logic [11:0] src_len;
  logic [11:0] app_end;
  logic [3:0] limit;
  logic [1:0] use_rate;
  logic [3:0] pick;
  logic [25:0] ts_sum;
  logic [31:0] ts_word;
  logic start;
  logic advance;
  logic in_take;
  logic [31:0] rdmux;
  // dfs of zero means 256 quadlets; fn gives 2^fn blocks
  assign blk_q = (r.dfs == 8'h00) ? 9'h100 : {1'b0, r.dfs};
  assign nblk = 4'h1 << r.fn;
  assign src_len = {3'h0, blk_q} << r.fn;
  assign app_end = src_len - {9'h0, r.qpc};
  // carry out of bit 24 dropped on purpose: the stamp wraps like the timer
  assign ts_sum = {1'b0, cyc_timer_i} + {1'b0, r.delay};
  assign ts_word = {7'h00, ts_sum[24:0]};
  assign start = (r.state == CIP_IDLE) && r.en && cycle_start_i;
  assign advance = !r.tx_valid || tx_ready_i;
  assign in_take = in_valid_i && r.in_ready;
  // a new rate is only adopted on a source packet boundary, so the old
  // mode never leaves the stream half way through an aligned group
  assign use_rate = (r.sent == 4'h0) ? r.rate : r.act_rate;
  // per-cycle block budget and the blocks actually picked
  always_comb begin
    unique case (use_rate)
      CIP_RATE_ONE: limit = 4'h1;
      CIP_RATE_TWO: limit = 4'h2;
      CIP_RATE_FOUR: limit = 4'h4;
      CIP_RATE_WHOLE: limit = nblk;
    endcase
    // dvc has one block per packet, so the budget collapses to one
    pick = (limit > nblk) ? nblk : limit;
    // only a complete source packet is eligible; a lone block waits
    if (!r.full) begin
      pick = 4'h0;
    end
  end
  // register read mux
  always_comb begin
    rdmux = 32'h0;
    unique case (haddr_i[7:0])
      CIP_OFF_CTRL: rdmux = {28'h0, r.sph, r.rate, r.en};
      CIP_OFF_FMT: rdmux = {2'h0, r.sid, 2'h0, r.fnt, 3'h0, r.qpc, r.fn, r.dfs};
      CIP_OFF_FDF: rdmux = {8'h0, r.fdf};
      CIP_OFF_DELAY: rdmux = {7'h0, r.delay};
      CIP_OFF_STAT: rdmux = {17'h0, r.state, r.full, r.sent, r.dbc};
      default: rdmux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    // ahb address phase: capture, read data ready for the data phase
    if (r.a_wr) begin
      unique case (r.a_addr)
        CIP_OFF_CTRL: begin
          n.en = hwdata_i[CIP_CTRL_EN];
          n.rate = hwdata_i[CIP_CTRL_RATE +: 2];
          if (!r.en) begin
            n.sph = hwdata_i[CIP_CTRL_SPH];
          end
        end
        CIP_OFF_FMT: begin
          // profile is locked while streaming, keeps dvc bandwidth fixed
          if (!r.en) begin
            n.dfs = hwdata_i[CIP_FMT_DFS +: 8];
            n.fn = hwdata_i[CIP_FMT_FN +: 2];
            n.qpc = hwdata_i[CIP_FMT_QPC +: 3];
            n.fnt = hwdata_i[CIP_FMT_FNT +: 6];
            n.sid = hwdata_i[CIP_FMT_SID +: 6];
          end
        end
        CIP_OFF_FDF: n.fdf = hwdata_i[23:0];
        CIP_OFF_DELAY: n.delay = hwdata_i[24:0];
        default: n.fdf = r.fdf;
      endcase
    end
    n.a_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      n.a_wr = hwrite_i;
      n.a_addr = haddr_i[7:0];
      n.hrdata = hwrite_i ? 32'h0 : rdmux;
    end
    n.hready = 1'b1;
    // input side: stamp goes in front of the first quadlet
    if (in_take) begin
      if (r.wr_ptr == 12'h0 && r.sph) begin
        n.mem[0] = ts_word;
        n.mem[1] = in_data_i;
        n.wr_ptr = 12'h2;
      end else begin
        n.mem[r.wr_ptr[AW-1:0]] = in_data_i;
        n.wr_ptr = r.wr_ptr + 12'h1;
      end
      // source packet complete once the payload (not padding) is in
      if (n.wr_ptr >= app_end) begin
        n.full = 1'b1;
      end
    end
    // output side
    if (advance) begin
      n.tx_valid = 1'b0;
      n.tx_sop = 1'b0;
      n.tx_eop = 1'b0;
    end
    unique case (r.state)
      CIP_IDLE: begin
        if (start) begin
          n.nsend = pick;
          n.act_rate = use_rate;
          n.hdr_dbc = r.dbc;
          n.dbc = r.dbc + {4'h0, pick};
          n.left = {8'h0, pick} * {3'h0, blk_q};
          n.tx_len = 12'h2 + {8'h0, pick} * {3'h0, blk_q};
          n.state = CIP_HDR0;
        end
      end
      CIP_HDR0: begin
        if (advance) begin
          n.tx_valid = 1'b1;
          n.tx_sop = 1'b1;
          n.tx_data = {CIP_HDR0_TOP, r.sid, r.dfs, r.fn, r.qpc, r.sph, 2'h0,
                       r.hdr_dbc};
          n.state = CIP_HDR1;
        end
      end
      CIP_HDR1: begin
        if (advance) begin
          n.tx_valid = 1'b1;
          n.tx_eop = (r.left == 12'h0);
          // dvc carries the frame pulse in syt; other formats send fdf as set
          n.tx_data = {CIP_HDR1_TOP, r.fnt, r.fdf};
          if (r.fnt == CIP_FNT_DVC) begin
            n.tx_data[15:0] = syt_i;
          end
          n.state = (r.left == 12'h0) ? CIP_IDLE : CIP_DATA;
        end
      end
      CIP_DATA: begin
        if (advance) begin
          n.tx_valid = 1'b1;
          // padding quadlets are sent as zero without being stored
          n.tx_data = (r.rd_ptr >= app_end) ? 32'h0 : r.mem[r.rd_ptr[AW-1:0]];
          n.rd_ptr = r.rd_ptr + 12'h1;
          n.left = r.left - 12'h1;
          if (r.left == 12'h1) begin
            n.tx_eop = 1'b1;
            n.state = CIP_IDLE;
            n.sent = r.sent + r.nsend;
            if (r.sent + r.nsend >= nblk) begin
              n.sent = 4'h0;
              n.rd_ptr = 12'h0;
              n.wr_ptr = 12'h0;
              n.full = 1'b0;
            end
          end
        end
      end
    endcase
    // single buffer: no new data until the held packet has drained
    n.in_ready = !n.full;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.sph <= CIP_RST_SPH;
      r.dfs <= CIP_RST_DFS;
      r.fn <= CIP_RST_FN;
      r.qpc <= CIP_RST_QPC;
      r.fnt <= CIP_RST_FNT;
      r.rate <= CIP_RST_RATE;
      r.delay <= CIP_RST_DELAY;
      r.hready <= 1'b1;
      r.state <= CIP_IDLE;
    end else if (ce_i) begin
      r <= n;
    end
  end
  // outputs straight from flip-flops, except hresp which is tied to okay
  assign hrdata_o = r.hrdata;
  assign hreadyout_o = r.hready;
  assign hresp_o = 1'b0;
  assign in_ready_o = r.in_ready;
  assign tx_data_o = r.tx_data;
  assign tx_valid_o = r.tx_valid;
  assign tx_sop_o = r.tx_sop;
  assign tx_eop_o = r.tx_eop;
  assign tx_len_o = r.tx_len;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    start && ce_i;
  endsequence
  sequence s_next;
    ce_i;
  endsequence
  a_empty_not_full: assert property ((s_start and !r.full) ##1 s_next |-> r.nsend == 4'h0)
    else $error("payload picked without a complete source packet");
  a_pair_align: assert property ((s_start and (use_rate == CIP_RATE_TWO && r.fn == 2'h3))
      |-> (pick == 4'h0 || pick == 4'h2) && !r.sent[0])
    else $error("pair mode payload misaligned");
  a_quad_align: assert property ((s_start and (use_rate == CIP_RATE_FOUR && r.fn == 2'h3))
      |-> (pick == 4'h0 || pick == 4'h4) && r.sent[1:0] == 2'h0)
    else $error("quad mode payload misaligned");
  a_whole_pkt: assert property ((s_start and use_rate == CIP_RATE_WHOLE)
      |-> (pick == 4'h0 || pick == nblk) && r.sent == 4'h0)
    else $error("partial source packet in whole mode");
  a_dvc_one: assert property ((s_start and r.fn == 2'h0) |-> pick <= 4'h1)
    else $error("more than one dvc block in a packet");
  a_dbc_step: assert property (s_start ##1 s_next
      |-> r.dbc == $past(r.dbc) + {4'h0, r.nsend} && r.hdr_dbc == $past(r.dbc))
    else $error("dbc did not advance by blocks sent");
  a_hdr_fields: assert property (r.tx_valid && r.tx_sop
      |-> r.tx_data[23:16] == r.dfs && r.tx_data[15:14] == r.fn
       && r.tx_data[10] == r.sph && r.tx_data[7:0] == r.hdr_dbc)
    else $error("cip header fields wrong");
  a_ts_stamp: assert property (in_take && ce_i && r.sph && r.wr_ptr == 12'h0
      ##1 1'b1 |-> r.mem[0][31:25] == 7'h00
       && r.mem[0][24:0] == $past(cyc_timer_i) + $past(r.delay))
    else $error("time stamp quadlet wrong");
  a_full_stall: assert property (r.full |-> !r.in_ready)
    else $error("input accepted while packet buffer full");
  a_pkt_bound: assert property (r.tx_valid && r.tx_sop && tx_ready_i && ce_i
      |=> r.tx_valid && !r.tx_sop)
    else $error("header second quadlet missing");

endmodule // cip_packer

/* verif/cip_link_model.sv */
`timescale 1ns/1ns
module cip_link_model (
  // clock, reset, stall control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  // quadlets from the packer
  input wire logic [31:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_sop_i,
  input wire logic tx_eop_i,
  input wire logic [11:0] tx_len_i,
  output logic tx_ready_o,
  // last packet seen
  output int pkts_o,
  output logic [31:0] hdr0_o,
  output logic [31:0] hdr1_o,
  output logic [31:0] first_o,
  output logic [31:0] last_o,
  output logic [11:0] len_o,
  output logic [11:0] nq_o
);
  logic phase_r;
  logic [11:0] cnt_r;

  // a stalling link takes every other cycle only, to stretch each quadlet
  assign tx_ready_o = !stall_i || phase_r;

  // capture headers, first and last payload quadlet of each packet
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
      cnt_r <= 12'h0;
      pkts_o <= 0;
    end else begin
      phase_r <= ~phase_r;
      if (tx_valid_i && tx_ready_o) begin
        if (tx_sop_i) begin
          hdr0_o <= tx_data_i;
          len_o <= tx_len_i;
          cnt_r <= 12'h1;
        end else begin
          cnt_r <= cnt_r + 12'h1;
        end
        if (!tx_sop_i && cnt_r == 12'h1) hdr1_o <= tx_data_i;
        if (!tx_sop_i && cnt_r == 12'h2) first_o <= tx_data_i;
        if (tx_eop_i) begin
          last_o <= tx_data_i;
          nq_o <= cnt_r + 12'h1;
          pkts_o <= pkts_o + 1;
        end
      end
    end
  end
endmodule // cip_link_model

/* verif/tb.sv */
`timescale 1ns/1ns
module tb;
  import cip_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, in_valid = 1'b0, cs = 1'b0, stall = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, in_data = 32'h0, rd;
  logic [31:0] hrdata, tx_data, hdr0, hdr1, first_d, last_d, s;
  logic hready, hresp, in_ready, tx_valid, tx_sop, tx_eop, tx_ready;
  logic [11:0] tx_len, len, nq;
  logic [7:0] exp_dbc;
  int pkts, n_mismatch = 0, check_count = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  // ce and hsize tied: hsize is ignored, ce freezing is not exercised
  cip_packer u_cip_packer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .in_data_i(in_data), .in_valid_i(in_valid), .in_ready_o(in_ready),
    .cycle_start_i(cs), .cyc_timer_i(25'h1ffff80), .syt_i(16'h5a5a), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_sop_o(tx_sop), .tx_eop_o(tx_eop), .tx_len_o(tx_len),
    .tx_ready_i(tx_ready));

  cip_link_model u_cip_link_model (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_sop_i(tx_sop), .tx_eop_i(tx_eop),
    .tx_len_i(tx_len), .tx_ready_o(tx_ready), .pkts_o(pkts), .hdr0_o(hdr0),
    .hdr1_o(hdr1), .first_o(first_d), .last_o(last_d), .len_o(len), .nq_o(nq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one single ahb-lite transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask

  // application quadlets numbered from a fixed base
  task automatic feed(input int n);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      in_data <= 32'hc0de0000 + i;
      in_valid <= 1'b1;
      @(posedge clk_i);
      while (in_ready !== 1'b1) @(posedge clk_i);
    end
    in_valid <= 1'b0;
  endtask

  // one isochronous cycle, then wait for the packet to finish
  task automatic pkt;
    int p0;
    p0 = pkts;
    @(posedge clk_i);
    cs <= 1'b1;
    @(posedge clk_i);
    cs <= 1'b0;
    while (pkts == p0) @(posedge clk_i);
    @(posedge clk_i);
  endtask

  // watchdog: the tests need about a thousand cycles
  initial begin
    #(50 * 20000);
    n_mismatch++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    ahb(1'b0, CIP_OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h00000008);
    chk("resp okay", {31'h0, hresp}, 32'h0);
    ahb(1'b0, CIP_OFF_FMT, 32'h0);
    chk("fmt reset", rd, 32'h00200306);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, CIP_OFF_DELAY, 32'h100);
    ahb(1'b1, CIP_OFF_CTRL, 32'hf);
    // nothing buffered: header-only packet
    pkt;
    chk("empty len", {20'h0, nq}, 32'd2);
    chk("empty hdr0", hdr0, 32'h0006c400);
    chk("empty hdr1", hdr1, 32'ha0000000);
    // whole transport packet; stamp wraps past 25 bits
    feed(47);
    @(posedge clk_i);
    chk("in stall", {31'h0, in_ready}, 32'h0);
    pkt;
    chk("in resume", {31'h0, in_ready}, 32'h1);
    chk("ts len", {20'h0, len}, 32'd50);
    chk("ts count", {20'h0, nq}, 32'd50);
    chk("ts hdr0", hdr0, 32'h0006c400);
    chk("ts stamp", first_d, 32'h00000080);
    chk("ts last", last_d, 32'hc0de002e);
    exp_dbc = 8'h08;
    // rate modes changed mid-stream with a slow link
    stall <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      ahb(1'b1, CIP_OFF_CTRL, 32'h9 | (r << 1));
      feed(47);
      for (int j = 0; j < (8 >> r); j++) begin
        pkt;
        s = j * (6 << r);
        chk("rate len", {20'h0, nq}, 2 + (6 << r));
        chk("rate dbc", {24'h0, hdr0[7:0]}, {24'h0, exp_dbc});
        chk("rate align", first_d, s == 0 ? 32'h80 : 32'hc0de0000 + s - 1);
        exp_dbc = exp_dbc + (8'h1 << r);
      end
    end
    stall <= 1'b0;
    // dvc standard definition profile
    ahb(1'b1, CIP_OFF_CTRL, 32'h6);
    ahb(1'b1, CIP_OFF_FMT, 32'h05000078);
    ahb(1'b1, CIP_OFF_FDF, 32'h00ab0000);
    ahb(1'b1, CIP_OFF_CTRL, 32'h7);
    ahb(1'b1, CIP_OFF_FMT, 32'h0);
    ahb(1'b0, CIP_OFF_FMT, 32'h0);
    chk("fmt locked", rd, 32'h05000078);
    feed(120);
    pkt;
    chk("dvc len", {20'h0, nq}, 32'd122);
    chk("dvc hdr0", hdr0, 32'h05780000 | exp_dbc);
    chk("dvc hdr1", hdr1, 32'h80ab5a5a);
    chk("dvc first", first_d, 32'hc0de0000);
    chk("dvc last", last_d, 32'hc0de0077);
    close_out;
  end
endmodule // tb
